// >>> hw/ccs_top.sv
// Context shadow stack, stack fault flags, table reads and indirect pointers.
`timescale 1ns/1ps
module ccs_top (
	input  wire logic                               i_clk,
	input  wire logic                               i_rstn,
	// AXI4-Lite slave.
	input  wire logic [ccs_pkg::AXI_ADDR_W-1:0]     i_s_axi_awaddr,
	input  wire logic                               i_s_axi_awvalid,
	output logic                                    o_s_axi_awready,
	input  wire logic [31:0]                        i_s_axi_wdata,
	input  wire logic [3:0]                         i_s_axi_wstrb,
	input  wire logic                               i_s_axi_wvalid,
	output logic                                    o_s_axi_wready,
	output logic [1:0]                              o_s_axi_bresp,
	output logic                                    o_s_axi_bvalid,
	input  wire logic                               i_s_axi_bready,
	input  wire logic [ccs_pkg::AXI_ADDR_W-1:0]     i_s_axi_araddr,
	input  wire logic                               i_s_axi_arvalid,
	output logic                                    o_s_axi_arready,
	output logic [31:0]                             o_s_axi_rdata,
	output logic [1:0]                              o_s_axi_rresp,
	output logic                                    o_s_axi_rvalid,
	input  wire logic                               i_s_axi_rready,
	// Core events and context.
	input  wire ccs_pkg::ccs_ctx_t                  i_ctx,
	input  wire logic                               i_int_vector,
	input  wire logic                               i_call_fast,
	input  wire logic                               i_return_from_interrupt_instr_fast,
	input  wire logic                               i_return_fast,
	input  wire logic                               i_stack_full_evt,
	input  wire logic                               i_stack_unf_evt,
	output logic                                    o_device_reset,
	output logic                                    o_restore_valid,
	output ccs_pkg::ccs_ctx_t                       o_restore,
	// Computed jump and literal return.
	input  wire logic                               i_pcl_add,
	input  wire logic [ccs_pkg::PC_W-1:0]           i_pc,
	input  wire logic                               i_return_with_literal_instr,
	input  wire logic [7:0]                         i_literal,
	output logic                                    o_pc_load,
	output logic [ccs_pkg::PC_W-1:0]                o_pc_next,
	output logic                                    o_working_load,
	output logic [7:0]                              o_working_value,
	// Table read port to program memory.
	input  wire logic                               i_tbl_read,
	input  wire logic                               i_tbl_post_increment_operand,
	output logic                                    o_pm_req,
	output logic [ccs_pkg::TBL_W-2:0]               o_pm_word_addr,
	input  wire logic                               i_pm_valid,
	input  wire logic [15:0]                        i_pm_word,
	// Indirect access port.
	input  wire logic                               i_ind_req,
	input  wire logic [1:0]                         i_ind_ptr,
	input  wire ccs_pkg::ccs_ind_mode_t             i_ind_mode,
	input  wire logic                               i_ind_we,
	input  wire logic [7:0]                         i_ind_wdata,
	output logic                                    o_mem_req,
	output ccs_pkg::ccs_mem_req_t                   o_mem,
	input  wire logic [7:0]                         i_mem_rdata,
	output logic                                    o_ind_done,
	output logic [7:0]                              o_ind_rdata,
	output logic                                    o_busy
);
	import ccs_pkg::*;

	localparam int AW = DATA_ADDR_W;

	// ********************************************************************
	// State.
	// ********************************************************************
	logic                 cfg_sre_q;
	logic [1:0]           flags_q;
	logic [1:0]           flags_d;
	logic                 rst_pend_q;
	ccs_ctx_t             shadow_q;
	logic [AW-1:0]        ptr_q [NUM_PTR];
	logic [TBL_W-1:0]     tbl_ptr_q;
	logic [7:0]           tbl_latch_q;
	ccs_state_t           state_q;
	logic                 tbl_inc_q;
	logic                 ind_rd_q;
	logic                 ind_virt_q;
	logic                 awready_q;
	logic                 wready_q;
	logic                 bvalid_q;
	logic [1:0]           bresp_q;
	logic                 arready_q;
	logic                 rvalid_q;
	logic [1:0]           rresp_q;
	logic [31:0]          rdata_q;
	logic [7:0]           aw_addr_q;
	logic                 aw_have_q;
	logic [31:0]          w_data_q;
	logic [3:0]           w_strb_q;
	logic                 w_have_q;

	// ********************************************************************
	// Bus write decode.
	// ********************************************************************
	// Address and data are latched separately, so either may come first.
	wire aw_take  = i_s_axi_awvalid & awready_q;
	wire w_take   = i_s_axi_wvalid & wready_q;
	wire wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
	wire wr_cfg   = wr_fire & (aw_addr_q == REG_CFG);
	wire wr_flags = wr_fire & (aw_addr_q == REG_STK_FLAGS);
	wire wr_ptr0  = wr_fire & (aw_addr_q == REG_PTR0);
	wire wr_ptr1  = wr_fire & (aw_addr_q == REG_PTR1);
	wire wr_ptr2  = wr_fire & (aw_addr_q == REG_PTR2);
	wire wr_tbl   = wr_fire & (aw_addr_q == REG_TBL_PTR);
	wire wr_latch = wr_fire & (aw_addr_q == REG_TBL_LATCH);
	wire wr_hit   = wr_cfg | wr_flags | wr_ptr0 | wr_ptr1 | wr_ptr2 |
		wr_tbl | wr_latch;
	wire [31:0] cfg_new = ccs_merge({31'h0, cfg_sre_q}, w_data_q, w_strb_q);
	wire [1:0]  flag_clr = (wr_flags & w_strb_q[0]) ? w_data_q[1:0] : 2'h0;
	wire [31:0] tbl_new = ccs_merge({11'h0, tbl_ptr_q}, w_data_q, w_strb_q);
	wire [2:0]  wr_ptr_sel = {wr_ptr2, wr_ptr1, wr_ptr0};

	// ********************************************************************
	// Bus read decode.
	// ********************************************************************
	// The shadow stack has no address, so software can never observe it.
	wire       ar_take = i_s_axi_arvalid & arready_q;
	wire [7:0] ra      = i_s_axi_araddr;
	wire       rd_hit  = (ra == REG_CFG) | (ra == REG_STK_FLAGS) |
		(ra == REG_PTR0) | (ra == REG_PTR1) | (ra == REG_PTR2) |
		(ra == REG_TBL_PTR) | (ra == REG_TBL_LATCH);
	wire [31:0] rd_word =
		(ra == REG_CFG)       ? {31'h0, cfg_sre_q} :
		(ra == REG_STK_FLAGS) ? {30'h0, flags_q} :
		(ra == REG_PTR0)      ? {20'h0, ptr_q[0]} :
		(ra == REG_PTR1)      ? {20'h0, ptr_q[1]} :
		(ra == REG_PTR2)      ? {20'h0, ptr_q[2]} :
		(ra == REG_TBL_PTR)   ? {11'h0, tbl_ptr_q} :
		(ra == REG_TBL_LATCH) ? {24'h0, tbl_latch_q} : 32'h0;

	// ********************************************************************
	// Indirect address generation.
	// ********************************************************************
	wire           idle     = (state_q == ST_IDLE);
	wire           ind_go   = idle & i_ind_req;
	wire           tbl_go   = idle & ~i_ind_req & i_tbl_read;
	wire [AW-1:0]  ptr_cur  = ptr_q[i_ind_ptr];
	wire [AW-1:0]  ptr_inc  = ptr_cur + 12'h001;
	wire [AW-1:0]  ptr_dec  = ptr_cur - 12'h001;
	// The offset sum is never written back.
	wire [AW-1:0]  ptr_offs = ptr_cur + ccs_sext(i_ctx.working);
	wire [AW-1:0]  ind_ea   =
		(i_ind_mode == IND_PRE_INCREMENT_OPERAND) ? ptr_inc :
		(i_ind_mode == IND_OFFSET_BY_WORKING_OPERAND)  ? ptr_offs :
		ptr_cur;
	wire           ptr_upd  = ind_go & ((i_ind_mode == IND_POST_DECREMENT_OPERAND) |
		(i_ind_mode == IND_POST_INCREMENT_OPERAND) | (i_ind_mode == IND_PRE_INCREMENT_OPERAND));
	wire [AW-1:0]  ptr_next = (i_ind_mode == IND_POST_DECREMENT_OPERAND) ? ptr_dec :
		ptr_inc;
	wire           ea_virt  = ccs_is_virtual(ind_ea);
	wire [TBL_W-1:0] tbl_inc = tbl_ptr_q + 21'h000001;
	wire [7:0]     tbl_byte = tbl_ptr_q[0] ? i_pm_word[15:8] :
		i_pm_word[7:0];

	// Fault flags: hardware set beats a software clear in the same cycle.
	assign flags_d = (flags_q & ~flag_clr) |
		{i_stack_unf_evt, i_stack_full_evt};

	// ********************************************************************
	// Bus slave handshake.
	// ********************************************************************
	// One write and one read at a time; ready drops while a beat is held.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr_q <= i_s_axi_awaddr;
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
			end
			if (w_take) begin
				w_data_q <= i_s_axi_wdata;
				w_strb_q <= i_s_axi_wstrb;
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
			end else if (bvalid_q & i_s_axi_bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// Read answers one cycle after the address is taken.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0;
		end else if (ar_take) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_q   <= rd_word;
		end else if (rvalid_q & i_s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	// ********************************************************************
	// Stack faults and device reset.
	// ********************************************************************
	// The flag lands first; the reset request follows one edge later so the
	// flag is already visible when the rest of the chip is reset. Only
	// i_rstn and a software clear write clear the flags, never the reset this block requests.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cfg_sre_q      <= CFG_SRE_RST;
			flags_q        <= FLAGS_RST;
			rst_pend_q     <= 1'b0;
			o_device_reset <= 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg_sre_q <= cfg_new[CFG_SRE_BIT];
			end
			flags_q        <= flags_d;
			rst_pend_q     <= cfg_sre_q &
				(i_stack_full_evt | i_stack_unf_evt);
			o_device_reset <= rst_pend_q;
		end
	end

	// ********************************************************************
	// Shadow context stack.
	// ********************************************************************
	// A single slot: any new save, including a nested interrupt, overwrites.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			shadow_q        <= '0;
			o_restore_valid <= 1'b0;
			o_restore       <= '0;
		end else begin
			if (i_int_vector | i_call_fast) begin
				shadow_q <= i_ctx;
			end
			// A plain interrupt return never raises the restore strobe.
			o_restore_valid <= i_return_from_interrupt_instr_fast | i_return_fast;
			o_restore       <= shadow_q;
		end
	end

	// ********************************************************************
	// Computed jump and literal return.
	// ********************************************************************
	// Odd offsets land mid-instruction; software must keep them even.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_pc_load       <= 1'b0;
			o_pc_next       <= '0;
			o_working_load  <= 1'b0;
			o_working_value <= 8'h00;
		end else begin
			o_pc_load       <= i_pcl_add;
			o_pc_next       <= i_pc + {13'h0, i_ctx.working};
			o_working_load  <= i_return_with_literal_instr;
			o_working_value <= i_literal;
		end
	end

	// ********************************************************************
	// Pointer pairs.
	// ********************************************************************
	// Core updates win over a bus write to the same pair in one cycle.
	// Nothing here touches status flags.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			for (int i = 0; i < NUM_PTR; i++) begin
				ptr_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_PTR; i++) begin
				if (ptr_upd && i_ind_ptr == i[1:0]) begin
					ptr_q[i] <= ptr_next;
				end else if (wr_ptr_sel[i]) begin
					// Whole-pair write; strobes are not merged here.
					ptr_q[i] <= w_data_q[AW-1:0];
				end
			end
		end
	end

	// ********************************************************************
	// Access sequencer.
	// ********************************************************************
	// Indirect accesses take two edges; a virtual target is never driven to
	// memory, so it cannot be read or written through another pointer.
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_q     <= ST_IDLE;
			o_mem_req   <= 1'b0;
			o_mem       <= '0;
			o_ind_done  <= 1'b0;
			o_ind_rdata <= 8'h00;
			ind_rd_q    <= 1'b0;
			ind_virt_q  <= 1'b0;
			o_pm_req    <= 1'b0;
			o_pm_word_addr <= '0;
			tbl_inc_q   <= 1'b0;
			tbl_ptr_q   <= '0;
			tbl_latch_q <= 8'h00;
			o_busy      <= 1'b0;
		end else begin
			o_mem_req  <= 1'b0;
			o_ind_done <= 1'b0;
			o_pm_req   <= 1'b0;
			if (wr_tbl & idle) begin
				tbl_ptr_q <= tbl_new[TBL_W-1:0];
			end
			unique case (state_q)
				ST_IDLE: begin
					if (ind_go) begin
						o_mem_req  <= ~ea_virt;
						o_mem.we   <= i_ind_we;
						o_mem.addr <= ind_ea;
						o_mem.wdata <= i_ind_wdata;
						ind_rd_q   <= ~i_ind_we;
						ind_virt_q <= ea_virt;
						o_busy     <= 1'b1;
						state_q    <= ST_IND_WAIT;
					end else if (tbl_go) begin
						o_pm_req       <= 1'b1;
						o_pm_word_addr <= tbl_ptr_q[TBL_W-1:1];
						tbl_inc_q      <= i_tbl_post_increment_operand;
						o_busy         <= 1'b1;
						state_q        <= ST_TBL_WAIT;
					end
				end
				ST_IND_WAIT: begin
					o_ind_rdata <= (ind_rd_q & ~ind_virt_q) ?
						i_mem_rdata : 8'h00;
					o_ind_done  <= 1'b1;
					o_busy      <= 1'b0;
					state_q     <= ST_IDLE;
				end
				ST_TBL_WAIT: begin
					if (i_pm_valid) begin
						tbl_latch_q <= tbl_byte;
						if (tbl_inc_q) begin
							tbl_ptr_q <= tbl_inc;
						end
						o_busy  <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					o_busy  <= 1'b0;
				end
			endcase
		end
	end

	// ********************************************************************
	// Output drive.
	// ********************************************************************
	assign o_s_axi_awready = awready_q;
	assign o_s_axi_wready  = wready_q;
	assign o_s_axi_bvalid  = bvalid_q;
	assign o_s_axi_bresp   = bresp_q;
	assign o_s_axi_arready = arready_q;
	assign o_s_axi_rvalid  = rvalid_q;
	assign o_s_axi_rresp   = rresp_q;
	assign o_s_axi_rdata   = rdata_q;

endmodule : ccs_top

// >>> include/ccs_pkg.sv
// Shared constants, types and helpers of the context stack and pointer unit.
// Overview of operation
// - Stack reset enabled: full or underflow sets its flag, then resets device.
// - Stack reset disabled: full or underflow sets its flag, no device reset.
// - Full and underflow flags stay set until software clear or power-on reset.
// - Shadow stack holds one status, working, bank copy; never bus-accessible.
// - Every interrupt vector copies status, working and bank into shadow.
// - A nested high-priority interrupt overwrites the low-priority shadow copy.
// - Fast interrupt return reloads the three registers; plain return does not.
// - Fast call saves the three registers into the shadow stack.
// - Fast subroutine return restores the three registers from the shadow.
// - Adding working to program counter low advances the counter by bytes.
// - Return with literal returns and hands the literal back in working.
// - Table read uses pointer as byte address, one byte into table latch.
// - Indirect operands are virtual and reach the location the pair addresses.
// - Post-decrement accesses at the pointer, then decrements the pair.
// - Post-increment accesses at the pointer, then increments the pair.
// - Pre-increment increments the pair first, then accesses the new value.
// - Offset operand accesses pointer plus signed working, -128 to 127.
// - Plain and offset operands leave pointer and working unchanged.
// - Increments and decrements span the pair; low rollover carries high.
// - Pointer updates by the operands alter no status flag.
// - Indirect access aimed at a virtual operand reads zero, writes nothing.
package ccs_pkg;

	// ********************************************************************
	// Register map of the bus slave.
	// ********************************************************************
	localparam int          AXI_ADDR_W     = 8;
	localparam logic [7:0]  REG_CFG        = 8'h00;
	localparam logic [7:0]  REG_STK_FLAGS  = 8'h04;
	localparam logic [7:0]  REG_PTR0       = 8'h08;
	localparam logic [7:0]  REG_PTR1       = 8'h0c;
	localparam logic [7:0]  REG_PTR2       = 8'h10;
	localparam logic [7:0]  REG_TBL_PTR    = 8'h14;
	localparam logic [7:0]  REG_TBL_LATCH  = 8'h18;
	localparam int          CFG_SRE_BIT    = 0;
	localparam int          FLAG_FULL_BIT  = 0;
	localparam int          FLAG_UNF_BIT   = 1;
	localparam logic        CFG_SRE_RST    = 1'b0;
	localparam logic [1:0]  FLAGS_RST      = 2'h0;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// ********************************************************************
	// Address space and virtual operand windows.
	// ********************************************************************
	localparam int          DATA_ADDR_W    = 12;
	localparam int          PC_W           = 21;
	localparam int          TBL_W          = 21;
	localparam int          NUM_PTR        = 3;
	localparam int          VIRT_OPS       = 5;
	localparam logic [11:0] VIRT_TOP0      = 12'hfef;
	localparam logic [11:0] VIRT_TOP1      = 12'hfe7;
	localparam logic [11:0] VIRT_TOP2      = 12'hfdf;

	// ********************************************************************
	// Types.
	// ********************************************************************
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] working;
		logic [7:0] bank;
	} ccs_ctx_t;

	typedef enum logic [2:0] {
		IND_PLAIN   = 3'b000,
		IND_POST_DECREMENT_OPERAND = 3'b001,
		IND_POST_INCREMENT_OPERAND = 3'b010,
		IND_PRE_INCREMENT_OPERAND  = 3'b011,
		IND_OFFSET_BY_WORKING_OPERAND   = 3'b100
	} ccs_ind_mode_t;

	typedef struct packed {
		logic                   we;
		logic [DATA_ADDR_W-1:0] addr;
		logic [7:0]             wdata;
	} ccs_mem_req_t;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_IND_WAIT = 2'b01,
		ST_TBL_WAIT = 2'b10
	} ccs_state_t;

	// Sign-extends an 8-bit offset to the data address width.
	function automatic logic [DATA_ADDR_W-1:0] ccs_sext(input logic [7:0] v);
		ccs_sext = {{(DATA_ADDR_W-8){v[7]}}, v};
	endfunction : ccs_sext

	// True when an address hits any of the virtual operand windows.
	function automatic logic ccs_is_virtual(
		input logic [DATA_ADDR_W-1:0] a);
		logic [DATA_ADDR_W-1:0] d0;
		logic [DATA_ADDR_W-1:0] d1;
		logic [DATA_ADDR_W-1:0] d2;
		d0 = VIRT_TOP0 - a;
		d1 = VIRT_TOP1 - a;
		d2 = VIRT_TOP2 - a;
		ccs_is_virtual = (a <= VIRT_TOP0 && d0 < VIRT_OPS) ||
			(a <= VIRT_TOP1 && d1 < VIRT_OPS) ||
			(a <= VIRT_TOP2 && d2 < VIRT_OPS);
	endfunction : ccs_is_virtual

	// Merges a bus write into an old word under its byte strobes.
	function automatic logic [31:0] ccs_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
		ccs_merge = old;
	endfunction : ccs_merge

endpackage : ccs_pkg

// >>> verification/ccs_top_properties.sv
// Concurrent checks on the ports of the context stack and pointer unit.
`timescale 1ns/1ps
module ccs_top_properties (
	input wire logic i_clk, i_rstn, i_int_vector, i_call_fast,
	i_return_from_interrupt_instr_fast, i_return_fast, i_stack_full_evt, i_stack_unf_evt,
	o_device_reset, o_restore_valid, i_pcl_add, o_pc_load, i_return_with_literal_instr,
	o_working_load, i_tbl_read, i_ind_req, o_busy, o_pm_req, o_ind_done,
	input wire ccs_pkg::ccs_ctx_t i_ctx, o_restore,
	input wire logic [ccs_pkg::PC_W-1:0] i_pc, o_pc_next,
	input wire logic [7:0] i_literal, o_working_value
);
	import ccs_pkg::*;
	// One clock domain, so clock and reset are given once for all checks.
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic save_any;
	logic ret_any;
	assign save_any = i_int_vector | i_call_fast;
	assign ret_any = i_return_from_interrupt_instr_fast | i_return_fast;

	property p_rst_cause;
		o_device_reset |-> $past(i_stack_full_evt | i_stack_unf_evt, 2);
	endproperty
	a_rst_cause: assert property (p_rst_cause)
		else $error("reset request without a stack fault");
	property p_restore;
		ret_any |=> o_restore_valid;
	endproperty
	a_restore: assert property (p_restore)
		else $error("fast return gave no restore");
	property p_restore_only;
		o_restore_valid |-> $past(ret_any);
	endproperty
	a_restore_only: assert property (p_restore_only)
		else $error("restore without a fast return");
	// The last save before a lone return decides the restored values.
	property p_shadow;
		save_any ##1 (ret_any && !save_any) |=> o_restore == $past(i_ctx, 2);
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("restored context differs from the saved one");
	property p_jump;
		i_pcl_add |=> o_pc_load && o_pc_next == $past(i_pc) + $past(i_ctx.working);
	endproperty
	a_jump: assert property (p_jump)
		else $error("computed jump target wrong");
	property p_jump_only;
		o_pc_load |-> $past(i_pcl_add);
	endproperty
	a_jump_only: assert property (p_jump_only)
		else $error("program counter load without a jump");
	property p_literal;
		i_return_with_literal_instr |=> o_working_load && o_working_value == $past(i_literal);
	endproperty
	a_literal: assert property (p_literal)
		else $error("literal return value wrong");
	property p_table;
		i_tbl_read && !i_ind_req && !o_busy |=> o_pm_req;
	endproperty
	a_table: assert property (p_table)
		else $error("table read issued no fetch");
	property p_ind;
		i_ind_req && !o_busy |=> o_busy ##1 (o_ind_done && !o_busy);
	endproperty
	a_ind: assert property (p_ind)
		else $error("indirect access timing wrong");
	c_reset: cover property (o_device_reset);
	c_shadow: cover property (save_any ##1 ret_any);
	c_ind: cover property (o_ind_done);
endmodule : ccs_top_properties

bind ccs_top ccs_top_properties i_props (.*);

// >>> verification/tb.sv
// Self-checking testbench of the context stack and pointer unit.
`timescale 1ns/1ps
module tb;
	import ccs_pkg::*;
	logic i_clk, i_rstn = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0,
		i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0,
		i_int_vector = 0, i_call_fast = 0, i_return_from_interrupt_instr_fast = 0,
		i_return_fast = 0, i_stack_full_evt = 0, i_stack_unf_evt = 0,
		i_pcl_add = 0, i_return_with_literal_instr = 0, i_tbl_read = 0, i_tbl_post_increment_operand = 1,
		i_pm_valid = 0, i_ind_req = 0, i_ind_we = 0;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready,
		o_s_axi_rvalid, o_device_reset, o_restore_valid, o_pc_load,
		o_working_load, o_pm_req, o_mem_req, o_ind_done, o_busy;
	logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0, i_literal = 0,
		i_ind_wdata = 8'h3c, i_mem_rdata = 8'hc3, o_working_value, o_ind_rdata;
	logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata;
	logic [3:0] i_s_axi_wstrb = 4'hf;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, i_ind_ptr = 0;
	logic [PC_W-1:0] i_pc = 0, o_pc_next;
	logic [19:0] o_pm_word_addr;
	logic [15:0] i_pm_word = 0;
	ccs_ctx_t i_ctx = 0, o_restore;
	ccs_ind_mode_t i_ind_mode = IND_PLAIN;
	ccs_mem_req_t o_mem;
	int n_errors, n_checks, n_rst;

	ccs_top i_dut (.*);

	// The 200 MHz clock, and a count of reset requests seen.
	initial begin
		i_clk = 0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (o_device_reset === 1'b1) n_rst++;

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	// Bus tasks hold each valid until its own ready is sampled, and each ready until its valid.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1;
		i_s_axi_wvalid <= 1;
		i_s_axi_bready <= 1;
		do begin
			@(posedge i_clk);
			if (o_s_axi_awready) i_s_axi_awvalid <= 0;
			if (o_s_axi_wready) i_s_axi_wvalid <= 0;
		end while (!o_s_axi_bvalid);
		i_s_axi_bready <= 0;
		chk(o_s_axi_bresp, RESP_OKAY);
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1;
		i_s_axi_rready <= 1;
		do begin
			@(posedge i_clk);
			if (o_s_axi_arready) i_s_axi_arvalid <= 0;
		end while (!o_s_axi_rvalid);
		i_s_axi_rready <= 0;
		chk(o_s_axi_rresp, r);
		if (r == RESP_OKAY) chk(o_s_axi_rdata, e);
	endtask : axr
	// One indirect access, then a read-back of the pointer pair it used.
	task automatic ind(input logic [1:0] p, input ccs_ind_mode_t m,
		input logic w, input logic v, input logic [11:0] a, input logic [11:0] n);
		i_ind_req <= 1;
		i_ind_ptr <= p;
		i_ind_mode <= m;
		i_ind_we <= w;
		@(posedge i_clk);
		i_ind_req <= 0;
		@(posedge i_clk);
		chk(o_mem_req, !v);
		if (!v) chk({o_mem.we, o_mem.addr, o_mem.wdata}, {w, a, i_ind_wdata});
		@(posedge i_clk);
		chk({o_ind_done, o_ind_rdata}, {1'b1, (w | v) ? 8'h00 : 8'hc3});
		axr(REG_PTR0 + {p, 2'b00}, {20'h0, n}, RESP_OKAY);
	endtask : ind
	task automatic finish_test;
		if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test

	// Cuts a hang short well beyond the roughly one hundred cycles of the run.
	initial begin
		repeat (20000) @(posedge i_clk);
		n_errors++;
		finish_test();
	end

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		repeat (12) @(posedge i_clk);
		i_rstn <= 1;
		@(posedge i_clk);
		axr(REG_CFG, 0, RESP_OKAY);
		axr(8'h40, 0, RESP_SLVERR);
		i_stack_full_evt <= 1;
		@(posedge i_clk);
		i_stack_full_evt <= 0;
		repeat (4) @(posedge i_clk);
		chk(n_rst, 0);
		axr(REG_STK_FLAGS, 1, RESP_OKAY);
		axw(REG_STK_FLAGS, 1);
		axr(REG_STK_FLAGS, 0, RESP_OKAY);
		axw(REG_CFG, 1);
		i_stack_unf_evt <= 1;
		@(posedge i_clk);
		i_stack_unf_evt <= 0;
		repeat (4) @(posedge i_clk);
		chk(n_rst, 1);
		axr(REG_STK_FLAGS, 2, RESP_OKAY);
		// Two nested vectors, then a fast interrupt return.
		i_ctx <= 24'h010203;
		i_int_vector <= 1;
		@(posedge i_clk);
		i_ctx <= 24'h0a0b0c;
		@(posedge i_clk);
		i_int_vector <= 0;
		i_return_from_interrupt_instr_fast <= 1;
		@(posedge i_clk);
		i_return_from_interrupt_instr_fast <= 0;
		i_ctx <= 24'h112233;
		i_call_fast <= 1;
		@(posedge i_clk);
		chk({o_restore_valid, o_restore}, {1'b1, 24'h0a0b0c});
		i_call_fast <= 0;
		i_return_fast <= 1;
		@(posedge i_clk);
		i_return_fast <= 0;
		@(posedge i_clk);
		chk({o_restore_valid, o_restore}, {1'b1, 24'h112233});
		// Computed jump and literal return side by side.
		i_ctx <= 24'h000600;
		i_pc <= 21'h0000f0;
		i_literal <= 8'h5a;
		i_pcl_add <= 1;
		i_return_with_literal_instr <= 1;
		@(posedge i_clk);
		i_pcl_add <= 0;
		i_return_with_literal_instr <= 0;
		i_ctx <= 24'h008000;
		@(posedge i_clk);
		chk({o_pc_load, o_pc_next}, {1'b1, 21'h0000f6});
		chk({o_working_load, o_working_value}, 9'h15a);
		// Pointer walks across the low-byte boundary in both directions.
		axw(REG_PTR0, 32'h0ff);
		ind(0, IND_POST_INCREMENT_OPERAND, 0, 0, 12'h0ff, 12'h100);
		ind(0, IND_POST_DECREMENT_OPERAND, 1, 0, 12'h100, 12'h0ff);
		ind(0, IND_PRE_INCREMENT_OPERAND, 0, 0, 12'h100, 12'h100);
		ind(0, IND_OFFSET_BY_WORKING_OPERAND, 0, 0, 12'h080, 12'h100);
		ind(0, IND_PLAIN, 1, 0, 12'h100, 12'h100);
		axw(REG_PTR1, 32'hfe7);
		ind(1, IND_PLAIN, 0, 1, 12'h000, 12'hfe7);
		ind(1, IND_PLAIN, 1, 1, 12'h000, 12'hfe7);
		// Odd byte address selects the high byte of the fetched word.
		axw(REG_TBL_PTR, 32'h3);
		i_tbl_read <= 1;
		@(posedge i_clk);
		i_tbl_read <= 0;
		@(posedge i_clk);
		chk({o_pm_req, o_pm_word_addr}, 21'h100001);
		i_pm_valid <= 1;
		i_pm_word <= 16'hbeef;
		@(posedge i_clk);
		i_pm_valid <= 0;
		@(posedge i_clk);
		axr(REG_TBL_LATCH, 32'hbe, RESP_OKAY);
		axr(REG_TBL_PTR, 32'h4, RESP_OKAY);
		finish_test();
	end
endmodule : tb
